/* File: cpd_change_pattern.sv */
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
// How it works
// - Bits whose ignore bit is set are excluded from change and pattern compares.
// - The per-port ignore register also selects drive type for output pins.
// - Each port has its own writable eight-bit match value.
// - In change mode the group raises its request internally on input change.
// - Timing select clear: compare unmasked pins every clock.
// - Timing select set: only samples with a request strobe can match.
// - Mismatch polarity set: hit flag asserts when unmasked lines differ.
// - Start or stop polarity flip is applied to the match used as trigger.
// - Change detector compares live data against last latched data.
// - Each of two groups has independent change and pattern circuits.
// - For input groups, stop select 3 picks the pattern match.
module cpd_change_pattern
  import cpd_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic [NUM_PORTS*PORT_W-1:0] pin_in,
  input wire logic [NUM_GROUPS-1:0] req_strobe,
  output logic [NUM_PORTS*PORT_W-1:0] drive_open_drain,
  output cpd_grp_out_t [NUM_GROUPS-1:0] grp_out
);

  ////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [PORT_W-1:0] match_value_bits_r [NUM_PORTS];
  logic [PORT_W-1:0] match_value_bits_nxt [NUM_PORTS];
  logic [PORT_W-1:0] ignore_bits_r [NUM_PORTS];
  logic [PORT_W-1:0] ignore_bits_nxt [NUM_PORTS];
  logic [7:0] match_ctrl_r [NUM_GROUPS];
  logic [7:0] match_ctrl_nxt [NUM_GROUPS];
  logic [7:0] trig_ctrl_r [NUM_GROUPS];
  logic [7:0] trig_ctrl_nxt [NUM_GROUPS];
  logic [NUM_PORTS-1:0] port_en_r [NUM_GROUPS];
  logic [NUM_PORTS-1:0] port_en_nxt [NUM_GROUPS];
  logic [7:0] rdata_nxt;
  logic [NUM_PORTS*PORT_W-1:0] drive_nxt;

  // Unmasked compare of one port, used by both detectors
  function automatic logic port_equal(input logic [PORT_W-1:0] a,
                                      input logic [PORT_W-1:0] b,
                                      input logic [PORT_W-1:0] ign);
    port_equal = ((a ^ b) & ~ign) == '0;
  endfunction

  // Write decode and readback; config is write-only, status reads back
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      match_value_bits_nxt[p] = match_value_bits_r[p];
      ignore_bits_nxt[p] = ignore_bits_r[p];
      if (wr_stb && addr == ADDR_PORT_A_MATCH + 8'(p)) begin
        match_value_bits_nxt[p] = wdata[PORT_W-1:0];
      end
      if (wr_stb && addr == ADDR_PORT_A_IGNORE + 8'(p)) begin
        ignore_bits_nxt[p] = wdata[PORT_W-1:0];
      end
    end
    for (int g = 0; g < NUM_GROUPS; g++) begin
      match_ctrl_nxt[g] = match_ctrl_r[g];
      trig_ctrl_nxt[g] = trig_ctrl_r[g];
      port_en_nxt[g] = port_en_r[g];
      if (wr_stb && addr == (g == 0 ? ADDR_G1_MATCH_CTRL : ADDR_G2_MATCH_CTRL)) begin
        match_ctrl_nxt[g] = wdata;
      end
      if (wr_stb && addr == ADDR_G1_TRIG_CTRL + 8'(g)) begin
        trig_ctrl_nxt[g] = wdata;
      end
      if (wr_stb && addr == ADDR_G1_PORT_EN + 8'(g)) begin
        port_en_nxt[g] = wdata[NUM_PORTS-1:0];
      end
    end
    rdata_nxt = RESET_BYTE;
    if (rd_stb && addr == ADDR_STATUS) begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        rdata_nxt[g] = grp_out[g].hit;
        rdata_nxt[g+4] = grp_out[g].change_req;
      end
    end
  end

  // Same ignore register doubles as open-drain select on output pins
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      drive_nxt[p*PORT_W +: PORT_W] = ignore_bits_r[p];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        match_value_bits_r[p] <= '0;
        ignore_bits_r[p] <= '0;
      end
      for (int g = 0; g < NUM_GROUPS; g++) begin
        match_ctrl_r[g] <= RESET_BYTE;
        trig_ctrl_r[g] <= RESET_BYTE;
        port_en_r[g] <= '0;
      end
      rdata <= RESET_BYTE;
      drive_open_drain <= '0;
    end else begin
      match_value_bits_r <= match_value_bits_nxt;
      ignore_bits_r <= ignore_bits_nxt;
      match_ctrl_r <= match_ctrl_nxt;
      trig_ctrl_r <= trig_ctrl_nxt;
      port_en_r <= port_en_nxt;
      rdata <= rdata_nxt;
      drive_open_drain <= drive_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One independent detector pair per group
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
    logic [NUM_PORTS*PORT_W-1:0] last_r;
    logic [NUM_PORTS*PORT_W-1:0] last_nxt;
    logic primed_r;
    logic primed_nxt;
    cpd_grp_out_t out_r;
    cpd_grp_out_t out_nxt;
    logic eq_all;
    logic chg;
    logic raw_hit;
    logic compare_timing_select;
    logic mismatch_polarity;
    logic change_mode;
    logic input_group;
    logic [1:0] start_trigger_select;
    logic [1:0] stop_trigger_select;
    logic start_polarity_flip;
    logic stop_polarity_flip;

    always_comb begin
      compare_timing_select = match_ctrl_r[g][CTL_TIMING_BIT];
      mismatch_polarity = match_ctrl_r[g][CTL_MISMATCH_BIT];
      start_trigger_select = trig_ctrl_r[g][TRG_START_SEL_LSB +: 2];
      stop_trigger_select = trig_ctrl_r[g][TRG_STOP_SEL_LSB +: 2];
      start_polarity_flip = trig_ctrl_r[g][TRG_START_FLIP_BIT];
      stop_polarity_flip = trig_ctrl_r[g][TRG_STOP_FLIP_BIT];
      change_mode = trig_ctrl_r[g][TRG_CHANGE_MODE_BIT];
      input_group = trig_ctrl_r[g][TRG_INPUT_BIT];
      // Disabled ports count as agreeing; no enabled port means no match (eq_all low)
      eq_all = |port_en_r[g];
      chg = 1'b0;
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (port_en_r[g][p]) begin
          if (!port_equal(pin_in[p*PORT_W +: PORT_W], match_value_bits_r[p],
                          ignore_bits_r[p])) begin
            eq_all = 1'b0;
          end
          if (!port_equal(pin_in[p*PORT_W +: PORT_W], last_r[p*PORT_W +: PORT_W],
                          ignore_bits_r[p])) begin
            chg = 1'b1;
          end
        end
      end
      raw_hit = eq_all ^ mismatch_polarity;
      out_nxt.hit = compare_timing_select ? (raw_hit && req_strobe[g]) : raw_hit;
      out_nxt.start_trig = input_group && start_trigger_select == SEL_PATTERN &&
                           (out_nxt.hit ^ start_polarity_flip);
      out_nxt.stop_trig = input_group && stop_trigger_select == SEL_PATTERN &&
                          (out_nxt.hit ^ stop_polarity_flip);
      // First sample after enabling only primes the reference
      out_nxt.change_req = change_mode && primed_r && chg;
      last_nxt = last_r;
      primed_nxt = primed_r && change_mode;
      if (change_mode && (chg || !primed_r)) begin
        last_nxt = pin_in;
        primed_nxt = 1'b1;
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        last_r <= '0;
        primed_r <= 1'b0;
        out_r <= '0;
      end else begin
        last_r <= last_nxt;
        primed_r <= primed_nxt;
        out_r <= out_nxt;
      end
    end

    assign grp_out[g] = out_r;
  end

endmodule

/* File: cpd_change_pattern_checker.sv */
`timescale 1ns/1ns
module cpd_change_pattern_checker
  import cpd_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire logic [NUM_PORTS*PORT_W-1:0] pin_in,
  input wire logic [NUM_GROUPS-1:0] req_strobe,
  input wire logic [NUM_PORTS*PORT_W-1:0] drive_open_drain,
  input wire cpd_grp_out_t [NUM_GROUPS-1:0] grp_out
);
  logic [7:0] c1_r;
  logic [7:0] t1_r;
  ////////////////////////////////////////////////////////////////
  // Snoop group 1 settings, the registers cannot be read back
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      c1_r <= 8'h00;
      t1_r <= 8'h00;
    end else if (wr_stb && addr == ADDR_G1_MATCH_CTRL) begin
      c1_r <= wdata;
    end else if (wr_stb && addr == ADDR_G1_TRIG_CTRL) begin
      t1_r <= wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_reset_clear: assert property (disable iff (1'b0) !reset_n |-> grp_out == '0)
    else $error("outputs not clear in reset");
  a_read_quiet: assert property (!$past(rd_stb) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  a_drive_source: assert property ($changed(drive_open_drain) |-> $past(wr_stb) || $past(wr_stb, 2))
    else $error("drive type changed without write");
  a_change_cause: assert property (grp_out[0].change_req |-> $past(pin_in) != $past(pin_in, 2))
    else $error("change request without line change");
  a_change_mode: assert property (grp_out[0].change_req |-> $past(t1_r[TRG_CHANGE_MODE_BIT]))
    else $error("change request outside change mode");
  a_stop_select: assert property (grp_out[0].stop_trig |-> $past(t1_r[4:3]) == SEL_PATTERN)
    else $error("stop trigger from unselected source");
  a_start_flip: assert property ($past(t1_r[1:0]) == SEL_PATTERN && $past(t1_r[7])
    |-> grp_out[0].start_trig == (grp_out[0].hit ^ $past(t1_r[2])))
    else $error("start trigger polarity wrong");
  a_sample_gate: assert property (c1_r[1:0] == 2'h1 && $stable(c1_r) && $rose(grp_out[0].hit)
    |-> $past(req_strobe[0]))
    else $error("sampled hit without strobe");
  c_hit: cover property (grp_out[0].hit);
  c_change: cover property (grp_out[0].change_req);
  c_stop: cover property (grp_out[0].stop_trig);
endmodule
bind cpd_change_pattern cpd_change_pattern_checker #(.PORT_W(PORT_W)) i_chk (.clk, .reset_n,
  .addr, .wdata, .wr_stb, .rd_stb, .rdata, .pin_in, .req_strobe, .drive_open_drain, .grp_out);

/* File: cpd_lines.sv */
`timescale 1ns/1ns
// Far-side input lines, launched just after each edge
module cpd_lines (
  input wire logic clk,
  input wire logic [31:0] pins_nxt,
  input wire logic [1:0] req_nxt,
  output logic [31:0] pins,
  output logic [1:0] req
);
  initial pins = 32'h0;
  initial req = 2'h0;
  // Strobe lasts as many cycles as it is asked for, but starts one edge later
  always @(posedge clk) begin
    pins <= pins_nxt;
    req <= req_nxt;
  end
endmodule

/* File: cpd_pkg.sv */
package cpd_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_PORT_A_MATCH = 8'h30;
  localparam logic [7:0] ADDR_PORT_B_MATCH = 8'h31;
  localparam logic [7:0] ADDR_PORT_C_MATCH = 8'h32;
  localparam logic [7:0] ADDR_PORT_D_MATCH = 8'h33;
  localparam logic [7:0] ADDR_G1_MATCH_CTRL = 8'h51;
  localparam logic [7:0] ADDR_G2_MATCH_CTRL = 8'h71;
  // Chosen offsets for loose bits
  localparam logic [7:0] ADDR_PORT_A_IGNORE = 8'h80;
  localparam logic [7:0] ADDR_G1_TRIG_CTRL = 8'h90;
  localparam logic [7:0] ADDR_G2_TRIG_CTRL = 8'h91;
  localparam logic [7:0] ADDR_G1_PORT_EN = 8'h92;
  localparam logic [7:0] ADDR_G2_PORT_EN = 8'h93;
  localparam logic [7:0] ADDR_STATUS = 8'h94;
  // Match control field positions
  localparam int CTL_TIMING_BIT = 0;
  localparam int CTL_MISMATCH_BIT = 1;
  // Trigger control field positions
  localparam int TRG_START_SEL_LSB = 0;
  localparam int TRG_START_FLIP_BIT = 2;
  localparam int TRG_STOP_SEL_LSB = 3;
  localparam int TRG_STOP_FLIP_BIT = 5;
  localparam int TRG_CHANGE_MODE_BIT = 6;
  localparam int TRG_INPUT_BIT = 7;
  localparam logic [1:0] SEL_PATTERN = 2'h3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int NUM_PORTS = 4;
  localparam int NUM_GROUPS = 2;

  // Per-group outputs that travel together
  typedef struct packed {
    logic hit;
    logic start_trig;
    logic stop_trig;
    logic change_req;
  } cpd_grp_out_t;
endpackage

/* File: test_change_and_pattern_detect.sv */
`timescale 1ns/1ns
module test_change_and_pattern_detect
  import cpd_pkg::*;
;
  logic clk = 0, reset_n = 0, wr_stb = 0, rd_stb = 0, rd_p = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, exp_q[$];
  logic [31:0] pn = 32'h0, pin_in, drv;
  logic [1:0] rq = 2'h0, req_strobe;
  logic [15:0] lf = 16'h4a77;
  cpd_grp_out_t [1:0] grp_out;
  int miscompares = 0, n_tests = 0, chg = 0, ex = 0;
  // Port B ignore register sits one byte above port A's
  localparam logic [7:0] ADDR_PORT_B_IGNORE_ALIAS = ADDR_PORT_A_IGNORE + 8'h01;
  cpd_change_pattern i_cpd_change_pattern (.clk, .reset_n, .addr, .wdata, .wr_stb, .rd_stb,
    .rdata, .pin_in, .req_strobe, .drive_open_drain(drv), .grp_out);
  cpd_lines i_cpd_lines (.clk, .pins_nxt(pn), .req_nxt(rq), .pins(pin_in), .req(req_strobe));
  initial forever #10 clk = ~clk;
  function automatic logic [15:0] nx(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task chk(string n, logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %h saw %h", n, e, s);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One-cycle strobes, then four idle edges after a write and one after a read, so no signal is set twice at once
  task wr(logic [7:0] a, logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task rd(logic [7:0] a, logic [7:0] e);
    addr <= a;
    rd_stb <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd_stb <= 1'b0;
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  // Read data is only valid in the slot after the strobe
  always @(posedge clk) begin
    if (rd_p) chk("rdata", rdata, exp_q.pop_front());
    if (grp_out[0].change_req) chg++;
    rd_p <= rd_stb;
  end
  initial begin
    #100000;
    miscompares++;
    finish_test;
  end
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(8'h20, 8'h00);
    rd(ADDR_PORT_A_MATCH, 8'h00);
    wr(ADDR_PORT_A_IGNORE, 8'h0f);
    wr(ADDR_PORT_A_MATCH, 8'ha0);
    wr(ADDR_G1_PORT_EN, 8'h01);
    pn <= {24'h0, 4'ha, lf[3:0]};
    wr(ADDR_G1_MATCH_CTRL, 8'h00);
    chk("drive", drv[7:0], 8'h0f);
    rd(ADDR_STATUS, 8'h01);
    pn[7:0] <= 8'h50;
    repeat (4) @(posedge clk);
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_G1_MATCH_CTRL, 8'h02);
    rd(ADDR_STATUS, 8'h01);
    wr(ADDR_G1_TRIG_CTRL, 8'h9f);
    chk("start", grp_out[0].start_trig, 0);
    chk("stop", grp_out[0].stop_trig, 1);
    pn[7:0] <= 8'ha3;
    wr(ADDR_G1_MATCH_CTRL, 8'h01);
    chk("unsampled", grp_out[0].hit, 0);
    rq <= 2'h1;
    @(posedge clk);
    rq <= 2'h0;
    // Mask bit 0 of port B so a toggle there alone must stay silent
    wr(ADDR_PORT_B_IGNORE_ALIAS, 8'h01);
    wr(ADDR_G1_PORT_EN, 8'h02);
    wr(ADDR_G1_TRIG_CTRL, 8'hc0);
    chg = 0;
    for (int i = 0; i < 24; i++) begin
      lf = nx(lf);
      if (((lf[7:0] ^ pn[15:8]) & 8'hfe) != 8'h00) ex++;
      pn[15:8] <= lf[7:0];
      repeat (3) @(posedge clk);
    end
    repeat (3) @(posedge clk);
    chk("changes", chg, ex);
    finish_test;
  end
endmodule
